// ---- lrs_pkg.sv ----
//------------------------------------------------------------------------------
// row scan driver constants, types and helpers
//------------------------------------------------------------------------------
package lrs_pkg;

  //----------------------------------------------------------------------------
  // geometry
  //----------------------------------------------------------------------------
  localparam int ROWS = 100;
  localparam int ROW_WORDS = 4;
  localparam int DW = 32;
  localparam int AW = 8;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam int CNT_W = 8;

  //----------------------------------------------------------------------------
  // register map (byte addresses)
  //----------------------------------------------------------------------------
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [AW-1:0] ADDR_FEED = 8'h08;
  localparam logic [AW-1:0] ADDR_PINS = 8'h0C;
  localparam logic [3:0] ROWS_PAGE = 4'h1;
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_FEED_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_BLANK_BIT = 2;
  localparam int STAT_TOKEN_BIT = 3;
  localparam int STAT_DIR_BIT = 4;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CNT_W-1:0] CNT_MAX = 8'hFF;

  //----------------------------------------------------------------------------
  // types
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    top_drive_level = 2'h0,
    upper_nonselect_level = 2'h1,
    lower_nonselect_level = 2'h2,
    deepest_drive_level = 2'h3
  } lrs_level_t;

  typedef struct packed {
    logic blank_to_top_n;
    logic blank_to_nonselect_n;
    logic ac_polarity;
    logic row_shift_clock;
    logic shift_direction_select;
  } lrs_pins_t;

  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } lrs_chain_t;

  localparam lrs_pins_t PINS_RESET = 5'h18;

  //----------------------------------------------------------------------------
  // stage bit and polarity to drive level
  //----------------------------------------------------------------------------
  function automatic lrs_level_t lrs_row_level(input logic stage, input logic pol);
    if (stage) begin
      return pol ? deepest_drive_level : top_drive_level;
    end
    return pol ? upper_nonselect_level : lower_nonselect_level;
  endfunction : lrs_row_level

endpackage : lrs_pkg

// ---- lrs_fifo.sv ----
//------------------------------------------------------------------------------
// synchronous fifo, flip-flop storage
//------------------------------------------------------------------------------
module lrs_fifo import lrs_pkg::*; #(
  parameter int W = FIFO_W,
  parameter int D = FIFO_D
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int PW = $clog2(D);
  localparam logic [PW:0] DEPTH = (PW+1)'(D);
  localparam logic [PW-1:0] LAST = (PW)'(D - 1);

  logic [W-1:0] mem_q [D];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage write
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : lrs_fifo

// ---- lrs_feed_serializer.sv ----
//------------------------------------------------------------------------------
// turns fifo bytes into chain input bits, lsb first
//------------------------------------------------------------------------------
module lrs_feed_serializer import lrs_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [FIFO_W-1:0] in_data,
  input wire logic advance,
  output logic bit_out
);
  localparam int BW = $clog2(FIFO_W);
  localparam logic [BW-1:0] BIT_LAST = (BW)'(FIFO_W - 1);

  logic [FIFO_W-1:0] byte_q;
  logic [BW-1:0] idx_q;
  logic have_q;
  logic last_use;

  // a byte is consumed bit by bit on each shift; empty feed gives zeros
  assign last_use = have_q & advance & (idx_q == BIT_LAST);
  assign in_ready = ~have_q | last_use;
  assign bit_out = have_q & byte_q[idx_q];

  // byte holder and bit index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      byte_q <= '0;
      idx_q <= '0;
      have_q <= 1'b0;
    end else if (in_valid && in_ready) begin
      byte_q <= in_data;
      idx_q <= '0;
      have_q <= 1'b1;
    end else if (last_use) begin
      have_q <= 1'b0;
      idx_q <= '0;
    end else if (have_q && advance) begin
      idx_q <= idx_q + 1'b1;
    end
  end

endmodule : lrs_feed_serializer

// ---- lrs_row_scan_driver.sv ----
//------------------------------------------------------------------------------
// row scan driver: 100-stage bidirectional scan register with axi4-lite access
//------------------------------------------------------------------------------
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
module lrs_row_scan_driver import lrs_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  // row pins from the timing controller
  input wire lrs_pins_t pins,
  // chain port a: in, out, enable
  input wire logic chain_port_a_in,
  output logic chain_port_a_out,
  output logic chain_port_a_oe,
  // chain port b: in, out, enable
  input wire logic chain_port_b_in,
  output logic chain_port_b_out,
  output logic chain_port_b_oe,
  // row drive level codes
  output lrs_level_t [ROWS-1:0] row_outputs,
  // axi4-lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DW-1:0] s_axi_wdata,
  input wire logic [DW/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  //----------------------------------------------------------------------------
  // declarations
  //----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } lrs_wr_state_t;

  lrs_wr_state_t wr_state_q;
  lrs_pins_t pins_q;
  logic [1:0] ctrl_q;
  logic [ROWS-1:0] stage_q;
  logic [ROWS-1:0] stage_d;
  logic [CNT_W-1:0] shift_cnt_q;
  logic blank_q;
  logic aw_held_q;
  logic w_held_q;
  logic [AW-1:0] awaddr_q;
  logic [DW-1:0] wdata_q;
  logic [DW/8-1:0] wstrb_q;
  logic variant_ns;
  logic blank;
  logic shift_fall;
  logic shift_go;
  logic chain_in;
  logic feed_bit;
  logic feed_valid;
  logic feed_ready;
  logic [FIFO_W-1:0] feed_data;
  logic fifo_in_ready;
  logic fifo_in_valid;
  logic wr_is_feed;
  logic do_write;

  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  // one 32-bit slice of the stage vector, upper bits zero
  function automatic logic [DW-1:0] rows_word(input logic [ROWS-1:0] s, input logic [1:0] idx);
    logic [ROW_WORDS*DW-1:0] ext;
    ext = '0;
    ext[ROWS-1:0] = s;
    return ext[idx*DW +: DW];
  endfunction : rows_word

  // address falls in the row snapshot page
  function automatic logic is_rows(input logic [AW-1:0] a);
    return a[AW-1:4] == ROWS_PAGE;
  endfunction : is_rows

  // known register addresses
  function automatic logic is_mapped(input logic [AW-1:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_FEED) || (a == ADDR_PINS) || is_rows(a);
  endfunction : is_mapped

  //----------------------------------------------------------------------------
  // pin sampling and event decode
  //----------------------------------------------------------------------------
  // previous pin state for falling edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_q <= PINS_RESET;
    end else begin
      pins_q <= pins;
    end
  end

  // variant picks which blanking input is honoured
  assign variant_ns = ctrl_q[CTRL_VARIANT_BIT];
  assign blank = variant_ns ? ~pins.blank_to_nonselect_n : ~pins.blank_to_top_n;
  assign shift_fall = pins_q.row_shift_clock & ~pins.row_shift_clock;
  assign shift_go = shift_fall & ~blank;

  // chain input comes from the feed fifo or from the input-side port
  assign chain_in = ctrl_q[CTRL_FEED_BIT] ? feed_bit
                  : (pins.shift_direction_select ? chain_port_b_in : chain_port_a_in);

  //----------------------------------------------------------------------------
  // scan register
  //----------------------------------------------------------------------------
  // next stage vector: clear on blanking, else shift on a falling edge
  always_comb begin
    stage_d = stage_q;
    if (blank) begin
      stage_d = '0;
    end else if (shift_fall) begin
      if (pins.shift_direction_select) begin
        stage_d = {chain_in, stage_q[ROWS-1:1]};
      end else begin
        stage_d = {stage_q[ROWS-2:0], chain_in};
      end
    end
  end

  // stage storage, one bit per row
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  // chain output: the bit leaving the far end at the shift edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_port_a_out <= 1'b0;
      chain_port_b_out <= 1'b0;
    end else if (blank) begin
      chain_port_a_out <= 1'b0;
      chain_port_b_out <= 1'b0;
    end else if (shift_fall) begin
      if (pins.shift_direction_select) begin
        chain_port_a_out <= stage_q[0];
      end else begin
        chain_port_b_out <= stage_q[ROWS-1];
      end
    end
  end

  // port roles follow the direction input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chain_port_a_oe <= 1'b0;
      chain_port_b_oe <= 1'b0;
    end else begin
      chain_port_a_oe <= pins.shift_direction_select;
      chain_port_b_oe <= ~pins.shift_direction_select;
    end
  end

  //----------------------------------------------------------------------------
  // row drive levels
  //----------------------------------------------------------------------------
  // levels track the next stage value so rows change with the shift
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      row_outputs <= '{default: top_drive_level};
    end else begin
      for (int i = 0; i < ROWS; i++) begin
        if (!blank) begin
          row_outputs[i] <= lrs_row_level(stage_d[i], pins.ac_polarity);
        end else if (variant_ns) begin
          row_outputs[i] <= pins.ac_polarity ? upper_nonselect_level : lower_nonselect_level;
        end else begin
          row_outputs[i] <= top_drive_level;
        end
      end
    end
  end

  //----------------------------------------------------------------------------
  // scan bookkeeping
  //----------------------------------------------------------------------------
  // blank flag and saturating count of shifts since last blanking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_q <= 1'b0;
      shift_cnt_q <= '0;
    end else begin
      blank_q <= blank;
      if (blank) begin
        shift_cnt_q <= '0;
      end else if (shift_go && shift_cnt_q != CNT_MAX) begin
        shift_cnt_q <= shift_cnt_q + 1'b1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // feed path: software bytes to chain input
  //----------------------------------------------------------------------------
  lrs_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(wdata_q[FIFO_W-1:0]),
    .out_valid(feed_valid),
    .out_ready(feed_ready),
    .out_data(feed_data)
  );

  lrs_feed_serializer u_ser (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(feed_valid),
    .in_ready(feed_ready),
    .in_data(feed_data),
    .advance(shift_go & ctrl_q[CTRL_FEED_BIT]),
    .bit_out(feed_bit)
  );

  //----------------------------------------------------------------------------
  // axi4-lite write side
  //----------------------------------------------------------------------------
  // a feed write waits for fifo room, stalling the response
  assign wr_is_feed = (awaddr_q == ADDR_FEED);
  assign do_write = (wr_state_q == WR_COLLECT) & aw_held_q & w_held_q & (~wr_is_feed | fifo_in_ready);
  assign fifo_in_valid = do_write & wr_is_feed & wstrb_q[0];

  // address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= WR_COLLECT;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        WR_COLLECT: begin
          if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_held_q <= 1'b1;
            s_axi_awready <= 1'b0;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_held_q <= 1'b1;
            s_axi_wready <= 1'b0;
          end
          if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            wr_state_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            wr_state_q <= WR_COLLECT;
          end
        end
      endcase
    end
  end

  // control register, low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (do_write && awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  //----------------------------------------------------------------------------
  // axi4-lite read side
  //----------------------------------------------------------------------------
  // one read at a time, data registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      s_axi_rdata <= '0;
      if (s_axi_araddr == ADDR_CTRL) begin
        s_axi_rdata[1:0] <= ctrl_q;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        s_axi_rdata[STAT_EMPTY_BIT] <= ~feed_valid;
        s_axi_rdata[STAT_FULL_BIT] <= ~fifo_in_ready;
        s_axi_rdata[STAT_BLANK_BIT] <= blank_q;
        s_axi_rdata[STAT_TOKEN_BIT] <= |stage_q;
        s_axi_rdata[STAT_DIR_BIT] <= pins_q.shift_direction_select;
        s_axi_rdata[STAT_CNT_LSB +: CNT_W] <= shift_cnt_q;
      end else if (s_axi_araddr == ADDR_PINS) begin
        s_axi_rdata[$bits(lrs_pins_t)-1:0] <= pins_q;
      end else if (is_rows(s_axi_araddr)) begin
        s_axi_rdata <= rows_word(stage_q, s_axi_araddr[3:2]);
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : lrs_row_scan_driver

// ---- lrs_row_scan_driver_sva.sv ----
//------------------------------------------------------------------------------
// row scan driver port checker
//------------------------------------------------------------------------------
module lrs_row_scan_driver_sva import lrs_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire lrs_pins_t pins,
  input wire logic chain_port_a_out,
  input wire logic chain_port_a_oe,
  input wire logic chain_port_b_out,
  input wire logic chain_port_b_oe,
  input wire lrs_level_t [ROWS-1:0] row_outputs,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic prev_clk_q, quiet, quiet_q, quiet_qq, fall;
  logic [2*ROWS-1:0] flat;
  logic [ROWS-1:0] lsb, stg, stg_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // row code to polarity bit and stage bit (top or deepest means set)
  always_comb begin
    flat = row_outputs;
    for (int i = 0; i < ROWS; i++) begin
      lsb[i] = flat[2*i];
      stg[i] = ~(flat[2*i] ^ flat[2*i+1]);
    end
  end
  assign quiet = pins.blank_to_top_n & pins.blank_to_nonselect_n;
  assign fall = prev_clk_q & ~pins.row_shift_clock;
  // history of scan clock, blanking and stage
  always_ff @(posedge aclk) begin
    prev_clk_q <= aresetn ? pins.row_shift_clock : 1'b0;
    quiet_q <= quiet;
    quiet_qq <= quiet_q;
    stg_q <= stg;
  end
  a_rows_pol_high: assert property ((quiet && pins.ac_polarity)[*4] |-> &lsb)
    else $error("rows not at high polarity levels");
  a_rows_pol_low: assert property ((quiet && !pins.ac_polarity)[*4] |-> lsb == '0)
    else $error("rows not at low polarity levels");
  a_blank_clears: assert property ((!pins.blank_to_top_n && !pins.blank_to_nonselect_n)[*3] |->
    !chain_port_a_out && !chain_port_b_out && (stg & lsb) == '0) else $error("blanking left a row selected");
  a_port_roles: assert property ($stable(pins.shift_direction_select)[*3] |->
    chain_port_a_oe == pins.shift_direction_select && chain_port_b_oe != pins.shift_direction_select)
    else $error("chain port enables wrong for direction");
  a_shift_up: assert property (fall && quiet && quiet_q && quiet_qq && $past(aresetn) &&
    !pins.shift_direction_select |=> stg[ROWS-1:1] == stg_q[ROWS-2:0] && chain_port_b_out == stg_q[ROWS-1])
    else $error("upward shift wrong");
  a_shift_down: assert property (fall && quiet && quiet_q && quiet_qq && $past(aresetn) &&
    pins.shift_direction_select |=> stg[ROWS-2:0] == stg_q[ROWS-1:1] && chain_port_a_out == stg_q[0])
    else $error("downward shift wrong");
  a_scan_holds: assert property (!fall && quiet && quiet_q && quiet_qq && $past(aresetn) |=> stg == stg_q)
    else $error("stage moved without falling scan edge");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  c_shift_up: cover property (fall && quiet && !pins.shift_direction_select);
  c_shift_down: cover property (fall && quiet && pins.shift_direction_select);
  c_both_blank: cover property ((!pins.blank_to_top_n && !pins.blank_to_nonselect_n)[*3]);
endmodule : lrs_row_scan_driver_sva

bind lrs_row_scan_driver lrs_row_scan_driver_sva u_lrs_row_scan_driver_sva (.aclk, .aresetn, .pins,
  .chain_port_a_out, .chain_port_a_oe, .chain_port_b_out, .chain_port_b_oe, .row_outputs,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- lrs_lcd_ctrl_model.sv ----
//------------------------------------------------------------------------------
// timing controller: scan clock, polarity, blanking, chain data
//------------------------------------------------------------------------------
module lrs_lcd_ctrl_model import lrs_pkg::*; (
  input wire logic aclk,
  output lrs_pins_t pins,
  output logic data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle: blanking inactive, scan clock low
  initial begin
    pins = PINS_RESET;
    data_o = 1'b0;
  end
  // static lines change just after an edge
  task automatic set_lines(input bit t, input bit n, input bit p, input bit r);
    @(posedge aclk);
    pins.blank_to_top_n <= t;
    pins.blank_to_nonselect_n <= n;
    pins.ac_polarity <= p;
    pins.shift_direction_select <= r;
  endtask : set_lines
  // one scan pulse, data held through the falling edge
  task automatic pulse(input bit d, input int hi, input int lo);
    @(posedge aclk);
    pins.row_shift_clock <= 1'b1;
    data_o <= d;
    repeat (hi) @(posedge aclk);
    pins.row_shift_clock <= 1'b0;
    @(posedge aclk);
    data_o <= ~d; // hold over: line no longer valid
    repeat (lo) @(posedge aclk);
  endtask : pulse
endmodule : lrs_lcd_ctrl_model

// ---- lrs_row_scan_driver_bench.sv ----
//------------------------------------------------------------------------------
// row scan driver bench
//------------------------------------------------------------------------------
module lrs_row_scan_driver_bench import lrs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, data_m, a_in, b_in, a_out, a_oe, b_out, b_oe;
  lrs_pins_t pins;
  lrs_level_t [ROWS-1:0] rows;
  logic [AW-1:0] awaddr, araddr;
  logic [DW-1:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  int errors, total_checks, cycles, variant, feed, dir, pol, k;
  bit bt, bn;
  bit st[ROWS];
  bit fbits[$];
  // the enabled end drives a chain wire, the controller otherwise
  assign a_in = a_oe ? a_out : data_m;
  assign b_in = b_oe ? b_out : data_m;
  lrs_lcd_ctrl_model u_lrs_lcd_ctrl_model (.aclk(aclk), .pins(pins), .data_o(data_m));
  lrs_row_scan_driver u_lrs_row_scan_driver (.aclk(aclk), .aresetn(aresetn), .pins(pins),
    .chain_port_a_in(a_in), .chain_port_a_out(a_out), .chain_port_a_oe(a_oe), .chain_port_b_in(b_in),
    .chain_port_b_out(b_out), .chain_port_b_oe(b_oe), .row_outputs(rows), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // hang guard
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end
  //----------------------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit aw, w;
    aw = 1;
    w = 1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        awvalid <= 1'b0;
        aw = 0;
      end
      if (w && wready) begin
        wvalid <= 1'b0;
        w = 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd
  function automatic bit blanked();
    return variant ? !bn : !bt;
  endfunction : blanked
  // expected code: 0 top, 1 upper, 2 lower, 3 deepest
  function automatic int exp_code(int i);
    if (blanked()) return variant ? (pol ? 1 : 2) : 0;
    if (st[i]) return pol ? 3 : 0;
    return pol ? 1 : 2;
  endfunction : exp_code
  task automatic check_rows();
    for (int i = 0; i < ROWS; i++) check("row", rows[i], exp_code(i));
  endtask : check_rows
  task automatic lines(input bit t, input bit n, input int p, input int d);
    bt = t;
    bn = n;
    pol = p;
    dir = d;
    u_lrs_lcd_ctrl_model.set_lines(t, n, p[0], d[0]);
    if (blanked()) st = '{default: 0};
    repeat (3) @(posedge aclk);
    check_rows();
  endtask : lines
  // pulses with random widths; model shifts beside the design
  task automatic shift(input int n);
    bit d, o;
    repeat (n) begin
      d = 1'($urandom_range(1, 0));
      u_lrs_lcd_ctrl_model.pulse(d, $urandom_range(3, 1), $urandom_range(3, 2));
      if (feed) d = fbits.size() > 0 ? fbits.pop_front() : 1'b0;
      o = 1'b0;
      if (!blanked() && dir == 0) begin
        o = st[ROWS-1];
        for (int i = ROWS - 1; i > 0; i--) st[i] = st[i-1];
        st[0] = d;
      end else if (!blanked()) begin
        o = st[0];
        for (int i = 0; i < ROWS - 1; i++) st[i] = st[i+1];
        st[ROWS-1] = d;
      end
      check("chain out", dir ? a_out : b_out, o);
      check_rows();
    end
  endtask : shift
  task automatic rows_regs();
    logic [31:0] e;
    for (int w = 0; w < 4; w++) begin
      e = '0;
      for (int i = 0; i < 32 && 32 * w + i < ROWS; i++) e[i] = st[32*w+i];
      axi_rd(8'h10 + 8'(4 * w), v, r);
      check("rows word", v, e);
    end
  endtask : rows_regs
  //----------------------------------------------------------------------------
  // tests
  //----------------------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    bt = 1;
    bn = 1;
    void'($urandom(11));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_PINS, v, r);
    check("pins", v, 32'h18);
    check_rows();
    $display("test reset done");
    lines(1, 1, 1, 0);
    shift(104);
    lines(1, 1, 0, 0);
    shift(20);
    lines(1, 1, 1, 1);
    shift(104);
    rows_regs();
    $display("test shift done");
    lines(1, 0, 0, 1);
    shift(3);
    lines(0, 1, 1, 1);
    shift(2);
    rows_regs();
    $display("test top blank done");
    axi_wr(ADDR_CTRL, {30'($urandom), 2'h1}, r);
    variant = 1;
    axi_rd(ADDR_CTRL, v, r);
    check("ctrl", v, 32'h1);
    lines(1, 1, 1, 0);
    shift(30);
    lines(1, 0, 1, 0);
    lines(1, 0, 0, 0);
    shift(2);
    lines(0, 1, 0, 0);
    shift(5);
    lines(0, 0, 1, 0);
    lines(1, 1, 0, 0);
    $display("test nonselect blank done");
    axi_wr(ADDR_CTRL, 32'h2, r);
    variant = 0;
    feed = 1;
    v = '0;
    for (k = 0; k < 20 && !v[STAT_FULL_BIT]; k++) begin
      v = $urandom;
      axi_wr(ADDR_FEED, {24'h0, v[7:0]}, r);
      for (int i = 0; i < 8; i++) fbits.push_back(v[i]);
      axi_rd(ADDR_STATUS, v, r);
    end
    check("full after", k, FIFO_D + 1);
    shift(fbits.size() + 2);
    axi_rd(ADDR_STATUS, v, r);
    check("status", v[15:0], {8'(8 * k + 2), 3'h0, dir[0], st.or(), 3'h1});
    $display("test feed done");
    axi_rd(8'h40, v, r);
    check("bad read", {v, r}, {32'h0, RESP_SLVERR});
    axi_wr(8'h44, 32'h3, r);
    check("bad write", r, RESP_SLVERR);
    axi_rd(ADDR_FEED, v, r);
    check("feed read", {v, r}, {32'h0, RESP_OKAY});
    $display("test bus done");
    stop_test();
  end
endmodule : lrs_row_scan_driver_bench
